/* File: design/memmap_pkg.sv */
// Package: address map, memory modes, DRAM timing constants and bundled types
package memmap_pkg;

  // ==========================================
  // Memory modes (select-one high, select-zero low)
  typedef enum logic [1:0] {
    MODE_0 = 2'b00,
    MODE_1 = 2'b01,
    MODE_2 = 2'b10,
    MODE_3 = 2'b11
  } mem_mode_t;

  // ==========================================
  // Address regions
  localparam logic [15:0] BOOT_ROM_LAST = 16'h0FFF;
  localparam logic [15:0] LOW_RAM_LAST = 16'h37FF;
  localparam logic [15:0] PRN_STAT_FIRST = 16'h37E8;
  localparam logic [15:0] PRN_STAT_LAST = 16'h37E9;
  localparam logic [15:0] KBD_FIRST = 16'h3800;
  localparam logic [15:0] KBD_LAST = 16'h3BFF;
  localparam logic [15:0] VID_FIRST = 16'h3C00;
  localparam logic [15:0] VID_LAST = 16'h3FFF;
  localparam logic [15:0] HI_KBD_FIRST = 16'hF400;
  localparam logic [15:0] HI_KBD_LAST = 16'hF7FF;
  localparam logic [15:0] HI_VID_FIRST = 16'hF800;

  // ==========================================
  // I/O port that maps the boot ROM (low bits ignored within 9C-9F)
  localparam logic [7:0] BOOT_PORT = 8'h9C;
  localparam logic [7:0] BOOT_PORT_MASK = 8'hFC;

  // ==========================================
  // Register interface: boot latch and status readback
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_BOOT_BIT = 0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BOOT_BIT = 2;
  localparam int STAT_BANKS_BIT = 3;
  localparam int STAT_CYCLE_BIT = 4;

  // ==========================================
  // DRAM sequencing times in ns, 200 MHz clock
  localparam int CLK_NS = 5;
  localparam int MUX_DELAY_NS = 40;
  localparam int CAS_DELAY_NS = 70;
  localparam int PRECHARGE_NS = 120;
  localparam int MEM_REQUEST_HIGH_MIN_NS = 110;
  // Delays are least times: round up
  localparam int MUX_CYC = (MUX_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_CYC = (CAS_DELAY_NS + CLK_NS - 1) / CLK_NS;
  // Shortening needed so request low ends early enough for full precharge
  localparam int SHORTEN_CYC = (PRECHARGE_NS - MEM_REQUEST_HIGH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DLY_W = 5;
  localparam logic [DLY_W-1:0] DLY_ZERO = 5'h00;

  // ==========================================
  // Bundles
  typedef struct packed {
    logic [15:0] addr;
    logic mem_request;
    logic rd;
    logic wr;
    logic opcode_fetch_cycle;
    logic refresh_indication;
  } cpu_bus_t;

  typedef struct packed {
    logic boot_rom;
    logic printer_status;
    logic keyboard;
    logic video;
    logic ram;
  } region_t;

endpackage

/* File: design/addr_decode.sv */
// Address map decoder for the four memory modes
`timescale 1ns/1ps
module addr_decode (
  input wire logic [15:0] i_addr,         // Processor address
  input wire logic i_rd,                  // Read strobe
  input wire logic i_wr,                  // Write strobe
  input wire memmap_pkg::mem_mode_t i_mode, // Memory mode
  input wire logic i_rom_en,              // ROM enabled
  output memmap_pkg::region_t o_region    // Selected region
);

  memmap_pkg::region_t r;
  logic in_boot;
  logic in_kbd;
  logic in_vid;
  logic in_prn;

  assign in_boot = i_addr <= memmap_pkg::BOOT_ROM_LAST;
  assign in_prn = (i_addr >= memmap_pkg::PRN_STAT_FIRST) && (i_addr <= memmap_pkg::PRN_STAT_LAST);
  assign in_kbd = (i_addr >= memmap_pkg::KBD_FIRST) && (i_addr <= memmap_pkg::KBD_LAST);
  assign in_vid = (i_addr >= memmap_pkg::VID_FIRST) && (i_addr <= memmap_pkg::VID_LAST);

  always_comb begin
    r = '0;
    unique case (i_mode)
      memmap_pkg::MODE_0: begin // R14
        if (i_rom_en && in_boot) begin
          r.boot_rom = 1'b1;
        end else if (in_prn) begin
          r.printer_status = 1'b1;
        end else if (in_kbd) begin
          r.keyboard = 1'b1;
        end else if (in_vid) begin
          r.video = 1'b1;
        end else if (i_addr <= memmap_pkg::LOW_RAM_LAST) begin
          // Low RAM is read only here: writes fall on nothing
          r.ram = i_rd && !i_wr;
        end else begin
          r.ram = 1'b1;
        end
      end
      memmap_pkg::MODE_1: begin // R16
        if (i_rom_en && in_boot) begin
          r.boot_rom = !i_wr;
          r.ram = i_wr;
        end else if (in_kbd) begin
          r.keyboard = 1'b1;
        end else if (in_vid) begin
          r.video = 1'b1;
        end else begin
          r.ram = 1'b1;
        end
      end
      memmap_pkg::MODE_2: begin // R15
        if (i_addr >= memmap_pkg::HI_VID_FIRST) begin
          r.video = 1'b1;
        end else if (i_addr >= memmap_pkg::HI_KBD_FIRST) begin
          r.keyboard = 1'b1;
        end else begin
          r.ram = 1'b1;
        end
      end
      memmap_pkg::MODE_3: begin // R15
        r.ram = 1'b1;
      end
    endcase
  end

  assign o_region = r;

endmodule

/* File: design/delay_tap.sv */
// Delay line replacement: cycles elapsed since a cycle start
`timescale 1ns/1ps
module delay_tap (
  input wire logic i_clk,                          // Clock
  input wire logic i_reset,                        // Sync reset
  input wire logic i_run,                          // Cycle in progress
  output logic [memmap_pkg::DLY_W-1:0] o_count     // Cycles since start
);

  logic [memmap_pkg::DLY_W-1:0] count_q;

  // Saturates so late taps stay asserted for long cycles
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_run) begin
      count_q <= memmap_pkg::DLY_ZERO;
    end else if (count_q != {memmap_pkg::DLY_W{1'b1}}) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign o_count = count_q;

endmodule

/* File: design/dram_memctl.sv */
// Memory map decode and dynamic RAM cycle control
//
// Notes on behaviour
// R1 - Boot port write of one maps boot ROM
// R2 - Boot mapping happens only in mode 0
// R3 - One bank 64K, two banks 128K
// R4 - Row then column address via mux strobe
// R5 - Data buffer enable/direction from map decode
// R6 - Row, mux, column strobes delayed from one start
// R7 - Shorten request during fast opcode fetch cycles
// R8 - Shortened request starts each RAM cycle
// R9 - RAM accesses never insert wait states
// R10 - No mux or column strobe during refresh
// R11 - Row strobe steered to selected bank only, both banks on refresh
// R12 - Column strobe latched until cycle end
// R13 - Column strobe suppressed on video access
// R14 - Mode 0 address map
// R15 - Modes 2 and 3 maps, ROM enable ignored
// R16 - Mode 1 map, ROM reads, RAM writes
// R17 - Mode from two select lines
`timescale 1ns/1ps
module dram_memctl (
  input wire logic I_CLK,                       // 200 MHz clock
  input wire logic I_RESET,                     // Sync reset, active high
  input wire logic [15:0] I_ADDR,               // Processor address
  input wire logic I_MEM_REQUEST,               // Memory request, active high
  input wire logic I_RD,                        // Read cycle
  input wire logic I_WR,                        // Write cycle
  input wire logic I_OPCODE_FETCH_CYCLE,        // Opcode fetch cycle
  input wire logic I_REFRESH_INDICATION,        // Refresh cycle
  input wire logic I_IO_WR,                     // I/O write strobe
  input wire logic [7:0] I_IO_ADDR,             // I/O port address
  input wire logic [7:0] I_IO_DATA,             // I/O write data
  input wire logic I_MAP_SELECT_LO,             // Map select bit 0
  input wire logic I_MAP_SELECT_HI,             // Map select bit 1
  input wire logic I_ROM_EN,                    // ROM enabled strap
  input wire logic I_FAST,                      // 4 MHz processor mode
  input wire logic I_TWO_BANKS,                 // 128K populated
  input wire logic I_WB_CYC,                    // Wishbone cycle
  input wire logic I_WB_STB,                    // Wishbone strobe
  input wire logic I_WB_WE,                     // Wishbone write enable
  input wire logic [3:0] I_WB_ADR,              // Wishbone byte address
  input wire logic [3:0] I_WB_SEL,              // Wishbone byte selects
  input wire logic [31:0] I_WB_DAT,             // Wishbone write data
  output logic [31:0] O_WB_DAT,                 // Wishbone read data
  output logic O_WB_ACK,                        // Wishbone acknowledge
  output logic O_WB_ERR,                        // Wishbone error
  output logic [7:0] O_DRAM_ADDR,               // Multiplexed DRAM address
  output logic O_BANK0_ROW_STROBE_N,            // Bank 0 row strobe
  output logic O_BANK1_ROW_STROBE_N,            // Bank 1 row strobe
  output logic O_ADDR_HALF_SELECT_N,            // Mux select, low = column
  output logic O_COLUMN_STROBE_N,               // Column strobe
  output logic O_DRAM_WE_N,                     // DRAM write enable
  output logic O_BUF_EN_N,                      // Data buffer enable
  output logic O_BUF_DIR,                       // Buffer dir, 1 = to processor
  output logic O_SEL_BOOT_ROM,                  // Boot ROM select
  output logic O_SEL_PRINTER_STATUS,            // Printer status select
  output logic O_SEL_KEYBOARD,                  // Keyboard select
  output logic O_SEL_VIDEO,                     // Video select
  output logic O_WAIT                           // Wait request to processor
);

  // ==========================================
  // Mode and boot latch
  memmap_pkg::mem_mode_t mode;
  memmap_pkg::cpu_bus_t bus;
  memmap_pkg::region_t region;
  logic boot_q;
  logic rom_map;
  logic boot_io_hit;
  logic wb_req;
  logic wb_ctrl_wr;

  assign mode = memmap_pkg::mem_mode_t'({I_MAP_SELECT_HI, I_MAP_SELECT_LO}); // R17
  assign bus = '{addr: I_ADDR, mem_request: I_MEM_REQUEST, rd: I_RD, wr: I_WR,
                 opcode_fetch_cycle: I_OPCODE_FETCH_CYCLE, refresh_indication: I_REFRESH_INDICATION};

  assign boot_io_hit = I_IO_WR && ((I_IO_ADDR & memmap_pkg::BOOT_PORT_MASK) == memmap_pkg::BOOT_PORT);
  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
  assign wb_ctrl_wr = wb_req && I_WB_WE && I_WB_SEL[0] && (I_WB_ADR == memmap_pkg::REG_CTRL);

  // Boot latch takes effect the cycle after the write, so the next fetch sees ROM
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      boot_q <= 1'b0;
    end else if (boot_io_hit) begin
      boot_q <= I_IO_DATA[0]; // R1
    end else if (wb_ctrl_wr) begin
      boot_q <= I_WB_DAT[memmap_pkg::CTRL_BOOT_BIT];
    end
  end

  // Latch only has mapping effect in mode 0
  assign rom_map = (I_ROM_EN || boot_q) && (mode == memmap_pkg::MODE_0) || // R2
                   I_ROM_EN && (mode == memmap_pkg::MODE_1);

  addr_decode u_decode (
    .i_addr(bus.addr),
    .i_rd(bus.rd),
    .i_wr(bus.wr),
    .i_mode(mode),
    .i_rom_en(rom_map),
    .o_region(region)
  );

  // ==========================================
  // Request shortening for fast opcode fetches
  logic req_q;
  logic [memmap_pkg::DLY_W-1:0] fetch_len_q;
  logic [memmap_pkg::DLY_W-1:0] last_len_q;
  logic [memmap_pkg::DLY_W-1:0] cut_len;
  logic shortened_mem_request;
  logic cycle_start;
  logic fetch_q;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      req_q <= 1'b0;
    end else begin
      req_q <= bus.mem_request;
    end
  end

  assign cycle_start = bus.mem_request && !req_q;

  // Fetch flag drops with the request, so learning looks at the flag of the cycle just ended
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= bus.opcode_fetch_cycle;
    end
  end

  // Learn the fetch low time so it can be cut by the precharge shortfall
  always_ff @(posedge I_CLK) begin
    // Cleared while idle so a stale length never cuts the start of the next cycle
    if (I_RESET || cycle_start || !bus.mem_request) begin
      fetch_len_q <= memmap_pkg::DLY_ZERO;
    end else if (bus.mem_request && fetch_len_q != {memmap_pkg::DLY_W{1'b1}}) begin
      fetch_len_q <= fetch_len_q + 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      last_len_q <= {memmap_pkg::DLY_W{1'b1}};
    end else if (!bus.mem_request && req_q && fetch_q) begin
      last_len_q <= fetch_len_q;
    end
  end

  assign cut_len = last_len_q - memmap_pkg::DLY_W'(memmap_pkg::SHORTEN_CYC);

  // Only opcode fetches at 4 MHz are cut; others follow the request
  assign shortened_mem_request = bus.mem_request &&
      !(I_FAST && bus.opcode_fetch_cycle && !bus.refresh_indication &&
        last_len_q > memmap_pkg::DLY_W'(memmap_pkg::SHORTEN_CYC) && fetch_len_q >= cut_len); // R7

  // ==========================================
  // Strobe sequence
  logic [memmap_pkg::DLY_W-1:0] tap;
  logic ram_cycle;
  logic cycle_row_strobe_n;
  logic delayed_column_strobe_n;
  logic cas_hold_q;
  logic bank_hi;

  assign ram_cycle = region.ram || region.video;

  delay_tap u_tap (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_run(shortened_mem_request), // R8
    .o_count(tap)
  );

  assign cycle_row_strobe_n = !(shortened_mem_request && (ram_cycle || bus.refresh_indication)); // R6
  assign delayed_column_strobe_n = !(tap >= memmap_pkg::DLY_W'(memmap_pkg::CAS_CYC));

  // Column strobe held from its tap until the processor request ends
  always_ff @(posedge I_CLK) begin
    if (I_RESET || !bus.mem_request) begin
      cas_hold_q <= 1'b0;
    end else if (!delayed_column_strobe_n && !cycle_row_strobe_n && !bus.refresh_indication) begin
      cas_hold_q <= 1'b1; // R12
    end
  end

  // Upper 32K goes to the second bank (128K uses bank 1 for the high half in every mode)
  assign bank_hi = I_TWO_BANKS && bus.addr[15]; // R3

  logic mux_q;
  logic row0_q;
  logic row1_q;
  logic col_q;
  logic we_q;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      row0_q <= 1'b1;
      row1_q <= 1'b1;
    end else begin
      row0_q <= cycle_row_strobe_n || (bank_hi && !bus.refresh_indication); // R11
      row1_q <= cycle_row_strobe_n || (!bank_hi && !bus.refresh_indication); // R11
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      mux_q <= 1'b1;
    end else begin
      mux_q <= cycle_row_strobe_n || bus.refresh_indication || // R10
               (tap < memmap_pkg::DLY_W'(memmap_pkg::MUX_CYC));
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      col_q <= 1'b1;
    end else begin
      col_q <= !(cas_hold_q && !bus.refresh_indication && !region.video); // R13
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      we_q <= 1'b1;
    end else begin
      we_q <= !(bus.wr && region.ram);
    end
  end

  assign O_BANK0_ROW_STROBE_N = row0_q;
  assign O_BANK1_ROW_STROBE_N = row1_q;
  assign O_ADDR_HALF_SELECT_N = mux_q;
  assign O_COLUMN_STROBE_N = col_q;
  assign O_DRAM_WE_N = we_q;

  // Row half A0-A7 while high, column half A8-A15 once switched
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_DRAM_ADDR <= 8'h00;
    end else begin
      O_DRAM_ADDR <= mux_q ? bus.addr[7:0] : bus.addr[15:8]; // R4
    end
  end

  // ==========================================
  // Buffer and region selects
  assign O_BUF_EN_N = !(region.ram && bus.mem_request && !bus.refresh_indication); // R5
  assign O_BUF_DIR = bus.rd; // R5
  assign O_SEL_BOOT_ROM = region.boot_rom && bus.mem_request;
  assign O_SEL_PRINTER_STATUS = region.printer_status && bus.mem_request;
  assign O_SEL_KEYBOARD = region.keyboard && bus.mem_request;
  assign O_SEL_VIDEO = region.video && bus.mem_request;
  assign O_WAIT = 1'b0; // R9

  // ==========================================
  // Register slave: one-cycle ack, unmapped answers err
  logic [31:0] rd_d;
  logic hit;

  assign hit = (I_WB_ADR == memmap_pkg::REG_CTRL) || (I_WB_ADR == memmap_pkg::REG_STATUS);

  always_comb begin
    rd_d = 32'h0000_0000;
    if (I_WB_ADR == memmap_pkg::REG_CTRL) begin
      rd_d[memmap_pkg::CTRL_BOOT_BIT] = boot_q;
    end else if (I_WB_ADR == memmap_pkg::REG_STATUS) begin
      rd_d[memmap_pkg::STAT_MODE_LSB +: 2] = mode;
      rd_d[memmap_pkg::STAT_BOOT_BIT] = rom_map;
      rd_d[memmap_pkg::STAT_BANKS_BIT] = I_TWO_BANKS;
      rd_d[memmap_pkg::STAT_CYCLE_BIT] = !cycle_row_strobe_n;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_WB_ACK <= 1'b0;
      O_WB_ERR <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= wb_req && hit;
      O_WB_ERR <= wb_req && !hit;
      O_WB_DAT <= (wb_req && hit && !I_WB_WE) ? rd_d : 32'h0000_0000;
    end
  end

endmodule

/* File: verification/memctl_assertions.sv */
// Checker: DRAM strobe order and register bus answers at the top ports
`timescale 1ns/1ps
module memctl_checker (
  input wire logic I_CLK, I_RESET, I_MEM_REQUEST, I_REFRESH_INDICATION, I_WB_CYC, I_WB_STB,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] O_DRAM_ADDR,
  input wire logic O_WB_ACK, O_WB_ERR, O_BANK0_ROW_STROBE_N, O_BANK1_ROW_STROBE_N,
  input wire logic O_ADDR_HALF_SELECT_N, O_COLUMN_STROBE_N, O_SEL_VIDEO, O_WAIT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic row_any;
  assign row_any = !O_BANK0_ROW_STROBE_N || !O_BANK1_ROW_STROBE_N;
  // ==========================================
  // DRAM sequencing and register bus answer
  no_wait_a: assert property (!O_WAIT) else $error("wait request raised");
  refresh_mux_a: assert property ($fell(O_ADDR_HALF_SELECT_N) |-> !I_REFRESH_INDICATION)
    else $error("mux select during refresh");
  video_col_a: assert property ($fell(O_COLUMN_STROBE_N) |-> !O_SEL_VIDEO)
    else $error("column strobe on video access");
  one_bank_a: assert property (!(I_REFRESH_INDICATION || $past(I_REFRESH_INDICATION) ||
    $past(I_REFRESH_INDICATION, 2)) |-> O_BANK0_ROW_STROBE_N || O_BANK1_ROW_STROBE_N)
    else $error("both banks strobed");
  col_hold_a: assert property (!O_COLUMN_STROBE_N && I_MEM_REQUEST |=> !O_COLUMN_STROBE_N)
    else $error("column strobe dropped early");
  mux_order_a: assert property ($fell(O_ADDR_HALF_SELECT_N) |-> $past(row_any, 6))
    else $error("mux select without row strobe");
  col_order_a: assert property ($fell(O_COLUMN_STROBE_N) |->
    !O_ADDR_HALF_SELECT_N && !$past(O_ADDR_HALF_SELECT_N, 4)) else $error("column before mux");
  col_addr_a: assert property (I_MEM_REQUEST && $past(I_MEM_REQUEST) && !O_ADDR_HALF_SELECT_N &&
    !$past(O_ADDR_HALF_SELECT_N, 2) |-> O_DRAM_ADDR == I_ADDR[15:8]) else $error("column half wrong");
  refresh_row_a: assert property ($rose(I_MEM_REQUEST) && I_REFRESH_INDICATION |->
    ##[1:3] (!O_BANK0_ROW_STROBE_N && !O_BANK1_ROW_STROBE_N)) else $error("refresh row strobe late");
  wb_answer_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR |=>
    O_WB_ACK != O_WB_ERR) else $error("bus answer missing");
endmodule

bind dram_memctl memctl_checker i_memctl_checker (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_MEM_REQUEST(I_MEM_REQUEST), .I_REFRESH_INDICATION(I_REFRESH_INDICATION), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_ADDR(I_ADDR), .O_DRAM_ADDR(O_DRAM_ADDR), .O_WB_ACK(O_WB_ACK),
  .O_WB_ERR(O_WB_ERR), .O_BANK0_ROW_STROBE_N(O_BANK0_ROW_STROBE_N),
  .O_BANK1_ROW_STROBE_N(O_BANK1_ROW_STROBE_N), .O_ADDR_HALF_SELECT_N(O_ADDR_HALF_SELECT_N),
  .O_COLUMN_STROBE_N(O_COLUMN_STROBE_N), .O_SEL_VIDEO(O_SEL_VIDEO), .O_WAIT(O_WAIT));

/* File: verification/dram_bank_model.sv */
// DRAM bank model: latches the address halves at the strobe edges
`timescale 1ns/1ps
module dram_bank_model (
  input wire logic i_bank0_row_strobe_n, // Bank 0 row strobe
  input wire logic i_bank1_row_strobe_n, // Bank 1 row strobe
  input wire logic i_column_strobe_n,    // Column strobe
  input wire logic [7:0] i_dram_addr,    // Multiplexed address
  output logic [7:0] o_row,              // Last row half taken
  output logic [7:0] o_col               // Last column half taken
);
  // ==========================================
  // Halves must already be settled when a strobe falls
  always @(negedge i_bank0_row_strobe_n or negedge i_bank1_row_strobe_n) begin
    o_row = i_dram_addr;
  end
  always @(negedge i_column_strobe_n) begin
    o_col = i_dram_addr;
  end
endmodule

/* File: verification/testbench.sv */
// Testbench: address map, DRAM strobes, boot latch and register bus
`timescale 1ns/1ps
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic [15:0] addr = 16'h0000;
  logic req = 0, rd = 0, wr = 0, m1 = 0, rf = 0, iow = 0, s_lo = 0, s_hi = 0, rom = 0, fast = 0, two = 0;
  logic cyc = 0, stb = 0, we = 0, latch = 0;
  logic [7:0] ioa = 8'h00, iod = 8'h00, daddr, m_row, m_col;
  logic [3:0] adr = 4'h0, wsel = 4'h0;
  logic [6:0] sels;
  logic we_n, buf_n;
  logic [31:0] wdat = 32'h0000_0000, rdat, q, rng = 32'hc410_c400;
  logic ack, err, e, b0_n, b1_n, mux_n, col_n, dir, s_boot, s_prn, s_kbd, s_vid, last_row;
  int n_mismatch = 0, cmp_count = 0, cycles = 0, b0s, b1s, muxs, cols;
  logic [15:0] tbl [18] = '{16'h0000, 16'h0fff, 16'h1000, 16'h37e7, 16'h37e8, 16'h37e9, 16'h37ea,
    16'h37ff, 16'h3800, 16'h3bff, 16'h3c00, 16'h3fff, 16'h4000, 16'h8005, 16'hf3ff, 16'hf400,
    16'hf7ff, 16'hf800};

  dram_memctl i_dram_memctl (
    .I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_MEM_REQUEST(req), .I_RD(rd), .I_WR(wr),
    .I_OPCODE_FETCH_CYCLE(m1), .I_REFRESH_INDICATION(rf), .I_IO_WR(iow), .I_IO_ADDR(ioa),
    .I_IO_DATA(iod), .I_MAP_SELECT_LO(s_lo), .I_MAP_SELECT_HI(s_hi), .I_ROM_EN(rom), .I_FAST(fast),
    .I_TWO_BANKS(two), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(wsel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_WB_ERR(err), .O_DRAM_ADDR(daddr),
    .O_BANK0_ROW_STROBE_N(b0_n), .O_BANK1_ROW_STROBE_N(b1_n), .O_ADDR_HALF_SELECT_N(mux_n),
    .O_COLUMN_STROBE_N(col_n), .O_DRAM_WE_N(we_n), .O_BUF_EN_N(buf_n), .O_BUF_DIR(dir),
    .O_SEL_BOOT_ROM(s_boot), .O_SEL_PRINTER_STATUS(s_prn), .O_SEL_KEYBOARD(s_kbd),
    .O_SEL_VIDEO(s_vid), .O_WAIT());
  dram_bank_model i_dram_bank_model (.i_bank0_row_strobe_n(b0_n), .i_bank1_row_strobe_n(b1_n),
    .i_column_strobe_n(col_n), .i_dram_addr(daddr), .o_row(m_row), .o_col(m_col));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ==========================================
  // Checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Tests take some 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected {boot, printer, keyboard, video}
  function automatic logic [3:0] exp_sel(input logic [15:0] a, input logic [1:0] md, input logic w);
    case (md)
      2'd2: return {2'b00, a >= 16'hf400 && a <= 16'hf7ff, a >= 16'hf800};
      2'd3: return 4'h0;
      default: return {!w && a <= 16'h0fff && (rom || (latch && md == 2'd0)),
        md == 2'd0 && !w && (a == 16'h37e8 || a == 16'h37e9), a[15:10] == 6'b001110, a[15:10] == 6'b001111};
    endcase
  endfunction

  // ==========================================
  // Bus drivers
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wsel, wdat} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic io_wr(input logic [7:0] d);
    @(posedge clk);
    {iow, ioa, iod} <= {1'b1, memmap_pkg::BOOT_PORT, d};
    @(posedge clk);
    iow <= 1'b0;
  endtask

  // Mode and address settle a cycle ahead of the request, so the row half is stable at the row strobe
  task automatic mem(input logic [15:0] a, input logic w, m, r, input logic [1:0] md, input int len);
    @(posedge clk);
    {s_hi, s_lo, addr} <= {md, a};
    @(posedge clk);
    {rd, wr, m1, rf, req} <= {!w, w, m, r, 1'b1};
    {b0s, b1s, muxs, cols} = '0;
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      #1;
      b0s += (b0_n === 1'b0);
      b1s += (b1_n === 1'b0);
      muxs += (mux_n === 1'b0);
      cols += (col_n === 1'b0);
      last_row = b0_n === 1'b0 || b1_n === 1'b0;
      if (i == 3) sels = {buf_n, we_n, dir, s_boot, s_prn, s_kbd, s_vid};
    end
    @(posedge clk);
    {rd, wr, m1, rf, req} <= 5'b0_0000;
    repeat (4) @(posedge clk);
  endtask

  task automatic run(input logic [15:0] a, input logic w, input logic [1:0] md);
    logic [3:0] ex;
    logic bk;
    logic rm;
    mem(a, w, 1'b0, 1'b0, md, 20);
    ex = exp_sel(a, md, w);
    bk = two && a[15];
    rm = ex == 4'h0 && !(md == 2'd0 && w && a < 16'h3800);
    check(sels, {!rm, !(rm && w), !w, ex});
    if (rm) begin
      check({b0s > 0, b1s > 0}, {!bk, bk});
      check({m_row, m_col, cols > 0}, {a[7:0], a[15:8], 1'b1});
    end else check({b0s + b1s > 0, cols > 0}, {ex == 4'h1, 1'b0});
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int md = 0; md < 4; md++) begin
      @(posedge clk);
      {s_hi, s_lo, two} <= {md[1:0], md[0]};
      wb(1'b0, 4'h4, 0);
      check(q[4:0], {1'b0, md[0], 1'b0, md[1:0]});
    end
    wb(1'b0, 4'h8, 0);
    check(e, 1'b1);
    $display("Test registers done");
    run(16'h0005, 1'b0, 2'd0);
    io_wr(8'h01);
    latch = 1'b1;
    run(16'h0005, 1'b0, 2'd0);
    wb(1'b0, 4'h4, 0);
    check(q[2], 1'b1);
    wb(1'b1, 4'h0, 0);
    latch = 1'b0;
    run(16'h0005, 1'b0, 2'd0);
    run(16'h0005, 1'b0, 2'd2);
    io_wr(8'h01);
    wb(1'b1, 4'h4, 32'hffff_ffff);
    wb(1'b0, 4'h4, 0);
    check(q[2:0], 3'b010);
    run(16'h0005, 1'b0, 2'd2);
    io_wr(8'h00);
    $display("Test boot latch done");
    for (int i = 0; i < 92; i++) begin
      rng = xs(rng);
      @(posedge clk);
      {rom, two} <= rng[17:16];
      if (i < 72) run(tbl[i % 18], 1'b0, 2'(i / 18));
      else run(rng[15:0], 1'b0, rng[19:18]);
    end
    run(16'h0100, 1'b1, 2'd1);
    run(16'h2000, 1'b1, 2'd0);
    $display("Test address map done");
    mem(rng[31:16], 1'b0, 1'b0, 1'b1, 2'd3, 20);
    check({b0s > 0, b1s > 0, muxs == 0, cols == 0}, 4'hf);
    $display("Test refresh done");
    @(posedge clk);
    fast <= 1'b1;
    mem(16'h8000, 1'b0, 1'b1, 1'b0, 2'd3, 24);
    mem(16'h8000, 1'b0, 1'b1, 1'b0, 2'd3, 24);
    check({last_row, cols > 0}, 2'b01);
    @(posedge clk);
    fast <= 1'b0;
    mem(16'h8000, 1'b0, 1'b1, 1'b0, 2'd3, 24);
    check({last_row, cols > 0}, 2'b11);
    $display("Test opcode fetch done");
    end_of_test();
  end
endmodule
